// ---- rtl/bolim_pkg.sv ----
// Package: register map, field layout, reset values and timing tables of the limiter bank
package bolim_pkg;

	// ------------------------------------------------------------
	// Register offsets
	// ------------------------------------------------------------
	localparam logic [7:0] OFS_L2_REL_CEIL = 8'h26;
	localparam logic [7:0] OFS_L2_TRIP_THR = 8'h27;
	localparam logic [7:0] OFS_L2_HOLD_DIS = 8'h28;
	localparam logic [7:0] OFS_L1_DWELL_ATK = 8'h29;
	localparam logic [7:0] OFS_L1_RATE_REL = 8'h2a;
	localparam logic [7:0] OFS_CTRL = 8'h3e;
	localparam logic [7:0] OFS_STATUS = 8'h3f;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [7:0] RST_L2_REL_CEIL = 8'h32;
	localparam logic [7:0] RST_L2_TRIP_THR = 8'h46;
	localparam logic [7:0] RST_L2_HOLD_DIS = 8'h20;
	localparam logic [7:0] RST_L1_DWELL_ATK = 8'h02;
	localparam logic [7:0] RST_L1_RATE_REL = 8'h06;
	localparam logic [7:0] RST_CTRL = 8'h00;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int F_HI3_LSB = 5;
	localparam int F_CEIL_LSB = 0;
	localparam int F_DIS_BIT = 4;
	localparam int F_STEP_LSB = 1;
	localparam int F_CTRL_SRC = 0;
	localparam int F_CTRL_HCLR = 1;
	localparam int F_CTRL_FRZ = 2;
	localparam int F_STAT_TRIP = 4;

	// ------------------------------------------------------------
	// Threshold mapping, millivolts
	// ------------------------------------------------------------
	localparam logic [16:0] THR_BATT_BASE_MV = 17'h00a8c;
	localparam logic [16:0] THR_PWR_BASE_MV = 17'h0157c;
	localparam logic [16:0] THR_STEP_MV = 17'h00032;
	localparam logic [7:0] THR_BATT_MAX_CODE = 8'h38;
	localparam logic [7:0] THR_PWR_MAX_CODE = 8'hd2;

	// ------------------------------------------------------------
	// Gain steps in units of 0.1 millidecibel
	// ------------------------------------------------------------
	localparam logic [18:0] STEP_CODE0 = 19'h00271;
	localparam logic [18:0] STEP_BASE = 19'h00412;
	localparam logic [18:0] STEP_INC = 19'h00f76;
	localparam logic [18:0] STEP_CODEF = 19'h0ea60;
	localparam logic [18:0] DB_UNITS = 19'h02710;
	localparam logic [2:0] HOLD_INF_CODE = 3'h7;

	// ------------------------------------------------------------
	// Timing tables and clock
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 40;
	localparam int NS_PER_US = 1000;
	localparam int US_PER_MS = 1000;
	localparam int REL_MS [8] = '{5, 10, 25, 50, 100, 250, 500, 1000};
	localparam int HOLD_MS [8] = '{0, 10, 100, 250, 500, 1000, 2000, 0};
	localparam int DWELL_US [8] = '{0, 100, 250, 500, 1000, 2000, 4000, 8000};
	localparam int ATK_NS [8] = '{2500, 5000, 10000, 25000, 50000, 100000, 250000, 500000};
	localparam int CYC_PER_US = NS_PER_US / CLK_PERIOD_NS;
	localparam int CYC_PER_MS = CYC_PER_US * US_PER_MS;

	// ------------------------------------------------------------
	// Limiter states and readout codes
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_DWELL = 3'h1,
		ST_ATTACK = 3'h3,
		ST_HOLD = 3'h2,
		ST_RELEASE = 3'h6
	} bolim_state_e;

	localparam logic [3:0] RD_IDLE = 4'h0;
	localparam logic [3:0] RD_ATTACK_L2 = 4'h2;
	localparam logic [3:0] RD_HOLD_L2 = 4'h6;
	localparam logic [3:0] RD_RELEASE_L2 = 4'ha;

endpackage : bolim_pkg

// ---- rtl/bolim_top.sv ----
// Brownout gain limiter: configuration bank, trip detect and level-2 attack/hold/release
//
// Our own choice: the strobed register port.
`timescale 1ns/1ps
module bolim_top #(
	parameter int P_CYC_PER_US = bolim_pkg::CYC_PER_US,
	parameter int P_CYC_PER_MS = bolim_pkg::CYC_PER_MS
) (
	input wire logic I_CLK,
	input wire logic I_RSTN,
	input wire logic [7:0] I_ADDR,
	input wire logic [7:0] I_WDATA,
	input wire logic I_WR,
	input wire logic I_RD,
	input wire logic [15:0] I_BATT_MV,
	input wire logic [15:0] I_PWR_MV,
	output logic [7:0] O_RDATA,
	output logic [18:0] O_ATTEN,
	output logic O_TRIP
);
	import bolim_pkg::*;

	// ------------------------------------------------------------
	// Decoding helpers
	// ------------------------------------------------------------
	function automatic logic [18:0] step_units(input logic [3:0] code);
		logic [18:0] r;
		r = STEP_BASE + 19'(STEP_INC * 19'(code));
		if (code == 4'h0) begin
			r = STEP_CODE0;
		end else if (code == 4'hf) begin
			r = STEP_CODEF;
		end
		return r;
	endfunction : step_units

	function automatic logic [31:0] ms_cyc(input int ms);
		return 32'(ms * P_CYC_PER_MS);
	endfunction : ms_cyc

	// ------------------------------------------------------------
	// Configuration registers
	// ------------------------------------------------------------
	logic [7:0] l2_rel_ceil_q;
	logic [7:0] l2_trip_thr_q;
	logic [7:0] l2_hold_dis_q;
	logic [7:0] l1_dwell_atk_q;
	logic [7:0] l1_rate_rel_q;
	logic [7:0] ctrl_q;
	logic hold_clr_q;
	logic [7:0] rdata_q;
	logic [3:0] readout_q;
	logic trip_q;
	logic [18:0] atten_q;
	logic [18:0] atten_d;
	logic [31:0] tmr_q;
	bolim_state_e state_q;
	bolim_state_e state_d;
	logic tmr_load;
	logic [31:0] tmr_val;
	logic atk_en;
	logic rel_en;

	wire logic wr_hit_ctrl = I_WR && (I_ADDR == OFS_CTRL);

	always_ff @(posedge I_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			l2_rel_ceil_q <= RST_L2_REL_CEIL;
			l2_trip_thr_q <= RST_L2_TRIP_THR;
			l2_hold_dis_q <= RST_L2_HOLD_DIS;
			l1_dwell_atk_q <= RST_L1_DWELL_ATK;
			l1_rate_rel_q <= RST_L1_RATE_REL;
			ctrl_q <= RST_CTRL;
		end else if (I_WR) begin
			case (I_ADDR)
				OFS_L2_REL_CEIL: begin
					l2_rel_ceil_q <= I_WDATA;
				end
				OFS_L2_TRIP_THR: begin
					l2_trip_thr_q <= I_WDATA;
				end
				// Low nibble is reserved and reads zero
				OFS_L2_HOLD_DIS: begin
					l2_hold_dis_q <= {I_WDATA[7:4], 4'h0};
				end
				OFS_L1_DWELL_ATK: begin
					l1_dwell_atk_q <= {I_WDATA[7:1], 1'b0};
				end
				OFS_L1_RATE_REL: begin
					l1_rate_rel_q <= {I_WDATA[7:1], 1'b0};
				end
				// Hold-clear is a strobe, never stored
				OFS_CTRL: begin
					ctrl_q <= {5'h00, I_WDATA[F_CTRL_FRZ], 1'b0, I_WDATA[F_CTRL_SRC]};
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge I_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			hold_clr_q <= 1'b0;
		end else begin
			hold_clr_q <= wr_hit_ctrl && I_WDATA[F_CTRL_HCLR];
		end
	end

	// ------------------------------------------------------------
	// Field views
	// ------------------------------------------------------------
	wire logic [2:0] lvl2_release_interval = l2_rel_ceil_q[F_HI3_LSB +: 3];
	wire logic [4:0] lvl2_atten_ceiling = l2_rel_ceil_q[F_CEIL_LSB +: 5];
	wire logic [2:0] lvl2_hold_duration = l2_hold_dis_q[F_HI3_LSB +: 3];
	wire logic lvl2_disable = l2_hold_dis_q[F_DIS_BIT];
	wire logic [2:0] lvl1_dwell_duration = l1_dwell_atk_q[F_HI3_LSB +: 3];
	wire logic [3:0] lvl1_attack_step = l1_dwell_atk_q[F_STEP_LSB +: 4];
	wire logic [2:0] lvl1_attack_interval = l1_rate_rel_q[F_HI3_LSB +: 3];
	wire logic [3:0] lvl1_release_step = l1_rate_rel_q[F_STEP_LSB +: 4];
	wire logic monitor_source_select = ctrl_q[F_CTRL_SRC];
	wire logic state_readout_freeze = ctrl_q[F_CTRL_FRZ];

	wire logic [18:0] ceil_units = 19'(DB_UNITS * 19'(lvl2_atten_ceiling));
	wire logic [18:0] atk_units = step_units(lvl1_attack_step);
	wire logic [18:0] rls_units = step_units(lvl1_release_step);
	wire logic hold_inf = (lvl2_hold_duration == HOLD_INF_CODE);

	// Interval lengths in clock cycles; fractional cycles are dropped
	// release interval
	wire logic [31:0] rel_cyc = ms_cyc(REL_MS[lvl2_release_interval]);
	wire logic [31:0] hold_cyc = ms_cyc(HOLD_MS[lvl2_hold_duration]);
	wire logic [31:0] dwell_cyc = 32'(DWELL_US[lvl1_dwell_duration] * P_CYC_PER_US);
	wire logic [31:0] atk_cyc = 32'((ATK_NS[lvl1_attack_interval] * P_CYC_PER_US) / NS_PER_US);

	// ------------------------------------------------------------
	// Trip detection
	// ------------------------------------------------------------
	logic [16:0] thr_mv;
	logic [16:0] rail_mv;

	always_comb begin
		rail_mv = {1'b0, I_BATT_MV};
		thr_mv = 17'h00000;
		if (monitor_source_select) begin
			rail_mv = {1'b0, I_PWR_MV};
			if (l2_trip_thr_q <= THR_PWR_MAX_CODE) begin
				thr_mv = THR_PWR_BASE_MV + 17'(THR_STEP_MV * 17'(l2_trip_thr_q));
			end
		end else begin
			if (l2_trip_thr_q <= THR_BATT_MAX_CODE) begin
				thr_mv = THR_BATT_BASE_MV + 17'(THR_STEP_MV * 17'(l2_trip_thr_q));
			end
		end
	end

	// A zero threshold never trips, so out-of-range codes silence the level
	always_ff @(posedge I_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			trip_q <= 1'b0;
		end else begin
			trip_q <= (thr_mv != 17'h00000) && (rail_mv < thr_mv) && !lvl2_disable;
		end
	end

	// ------------------------------------------------------------
	// Limiter sequencing
	// ------------------------------------------------------------
	wire logic tmr_done = (tmr_q == 32'h00000000);

	always_comb begin
		state_d = state_q;
		tmr_load = 1'b0;
		tmr_val = 32'h00000000;
		atk_en = 1'b0;
		rel_en = 1'b0;
		case (state_q)
			ST_IDLE: begin
				if (trip_q) begin
					state_d = ST_DWELL;
					tmr_load = 1'b1;
					tmr_val = dwell_cyc;
				end
			end
			// supply must stay low through the dwell
			ST_DWELL: begin
				if (!trip_q) begin
					state_d = ST_IDLE;
				end else if (tmr_done) begin
					state_d = ST_ATTACK;
					atk_en = 1'b1;
					tmr_load = 1'b1;
					tmr_val = atk_cyc;
				end
			end
			ST_ATTACK: begin
				if (!trip_q) begin
					state_d = ST_HOLD;
					tmr_load = 1'b1;
					tmr_val = hold_cyc;
				end else if (tmr_done) begin
					atk_en = 1'b1;
					tmr_load = 1'b1;
					tmr_val = atk_cyc;
				end
			end
			ST_HOLD: begin
				if (trip_q) begin
					state_d = ST_ATTACK;
					tmr_load = 1'b1;
					tmr_val = atk_cyc;
				end else if (hold_clr_q || (!hold_inf && tmr_done)) begin
					state_d = ST_RELEASE;
					tmr_load = 1'b1;
					tmr_val = rel_cyc;
				end
			end
			ST_RELEASE: begin
				if (trip_q) begin
					state_d = ST_ATTACK;
					tmr_load = 1'b1;
					tmr_val = atk_cyc;
				end else if (tmr_done) begin
					rel_en = 1'b1;
					if (atten_q <= rls_units) begin
						state_d = ST_IDLE;
					end else begin
						tmr_load = 1'b1;
						tmr_val = rel_cyc;
					end
				end
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
		if (lvl2_disable) begin
			state_d = ST_IDLE;
			atk_en = 1'b0;
			rel_en = 1'b0;
		end
	end

	always_ff @(posedge I_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			state_q <= ST_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	always_ff @(posedge I_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			tmr_q <= 32'h00000000;
		end else if (tmr_load) begin
			tmr_q <= tmr_val;
		end else if (!tmr_done) begin
			tmr_q <= tmr_q - 32'h00000001;
		end
	end

	// ------------------------------------------------------------
	// Attenuation accumulator
	// ------------------------------------------------------------
	always_comb begin
		atten_d = atten_q;
		if (atk_en) begin
			if ((atten_q + atk_units) >= ceil_units) begin
				atten_d = ceil_units;
			end else begin
				atten_d = atten_q + atk_units;
			end
		end else if (rel_en) begin
			if (atten_q <= rls_units) begin
				atten_d = 19'h00000;
			end else begin
				atten_d = atten_q - rls_units;
			end
		end
		if (lvl2_disable) begin
			atten_d = 19'h00000;
		end
	end

	always_ff @(posedge I_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			atten_q <= 19'h00000;
		end else begin
			atten_q <= atten_d;
		end
	end

	// ------------------------------------------------------------
	// State readout and read port
	// ------------------------------------------------------------
	// readout follows the state unless frozen
	always_ff @(posedge I_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			readout_q <= RD_IDLE;
		end else if (!state_readout_freeze) begin
			case (state_q)
				ST_ATTACK: begin
					readout_q <= RD_ATTACK_L2;
				end
				ST_HOLD: begin
					readout_q <= RD_HOLD_L2;
				end
				ST_RELEASE: begin
					readout_q <= RD_RELEASE_L2;
				end
				default: begin
					readout_q <= RD_IDLE;
				end
			endcase
		end
	end

	// Unmapped addresses read zero; read data lasts one cycle only
	always_ff @(posedge I_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			rdata_q <= 8'h00;
		end else if (I_RD) begin
			case (I_ADDR)
				OFS_L2_REL_CEIL: begin
					rdata_q <= l2_rel_ceil_q;
				end
				OFS_L2_TRIP_THR: begin
					rdata_q <= l2_trip_thr_q;
				end
				OFS_L2_HOLD_DIS: begin
					rdata_q <= l2_hold_dis_q;
				end
				OFS_L1_DWELL_ATK: begin
					rdata_q <= l1_dwell_atk_q;
				end
				OFS_L1_RATE_REL: begin
					rdata_q <= l1_rate_rel_q;
				end
				OFS_CTRL: begin
					rdata_q <= ctrl_q;
				end
				OFS_STATUS: begin
					rdata_q <= {3'h0, trip_q, readout_q};
				end
				default: begin
					rdata_q <= 8'h00;
				end
			endcase
		end else begin
			rdata_q <= 8'h00;
		end
	end

	assign O_RDATA = rdata_q;
	assign O_ATTEN = atten_q;
	assign O_TRIP = trip_q;

endmodule : bolim_top

// ---- sim/bolim_props.sv ----
// Port-level assertions for the limiter bank
`timescale 1ns/1ps
module bolim_props #(
	parameter int P_CYC_PER_US = 25,
	parameter int P_CYC_PER_MS = 25000
) (
	input wire logic I_CLK,
	input wire logic I_RSTN,
	input wire logic [7:0] I_ADDR,
	input wire logic [7:0] I_WDATA,
	input wire logic I_WR,
	input wire logic I_RD,
	input wire logic [15:0] I_BATT_MV,
	input wire logic [15:0] I_PWR_MV,
	input wire logic [7:0] O_RDATA,
	input wire logic [18:0] O_ATTEN,
	input wire logic O_TRIP
);
	import bolim_pkg::*;

	logic [7:0] r_q [5];
	logic src_q;
	logic [18:0] att_q, lim, astep, rstep;
	logic [16:0] tb_mv, tp_mv;
	logic up, dn, dis, eb, ep;
	function automatic logic [18:0] stepv(input logic [3:0] c);
		if (c == 4'h0) return STEP_CODE0;
		if (c == 4'hf) return STEP_CODEF;
		return STEP_BASE + STEP_INC * 19'(c);
	endfunction : stepv
	// ----
	// Shadow of the written configuration
	// ----
	always_ff @(posedge I_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			r_q <= '{RST_L2_REL_CEIL, RST_L2_TRIP_THR, RST_L2_HOLD_DIS, RST_L1_DWELL_ATK,
				RST_L1_RATE_REL};
			src_q <= 1'b0;
		end else if (I_WR) begin
			if (I_ADDR >= OFS_L2_REL_CEIL && I_ADDR <= OFS_L1_RATE_REL) begin
				r_q[3'(I_ADDR - OFS_L2_REL_CEIL)] <= I_WDATA;
			end
			if (I_ADDR == OFS_CTRL) begin
				src_q <= I_WDATA[F_CTRL_SRC];
			end
		end
	end
	always_ff @(posedge I_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			att_q <= '0;
		end else begin
			att_q <= O_ATTEN;
		end
	end
	assign lim = 19'(r_q[0][4:0]) * DB_UNITS;
	assign dis = r_q[2][F_DIS_BIT];
	assign astep = stepv(r_q[3][4:1]);
	assign rstep = stepv(r_q[4][4:1]);
	assign tb_mv = THR_BATT_BASE_MV + THR_STEP_MV * 17'(r_q[1]);
	assign tp_mv = THR_PWR_BASE_MV + THR_STEP_MV * 17'(r_q[1]);
	assign eb = !dis && r_q[1] <= THR_BATT_MAX_CODE && 17'(I_BATT_MV) < tb_mv;
	assign ep = !dis && r_q[1] <= THR_PWR_MAX_CODE && 17'(I_PWR_MV) < tp_mv;
	assign up = O_ATTEN > att_q;
	assign dn = O_ATTEN < att_q;
	// ----
	// Properties
	// ----
	default clocking cb @(posedge I_CLK); endclocking
	default disable iff (!I_RSTN);
	property p_rd_idle; !I_RD |=> O_RDATA == 8'h00; endproperty
	property p_stat_trip; I_RD && I_ADDR == OFS_STATUS |=> O_RDATA[4] == $past(O_TRIP); endproperty
	property p_trip_batt; !src_q |=> O_TRIP == $past(eb); endproperty
	property p_trip_pwr; src_q |=> O_TRIP == $past(ep); endproperty
	property p_dis; dis |=> O_ATTEN == '0 && !O_TRIP; endproperty
	// A lowered ceiling clamps downward, so only rising steps are bounded
	property p_ceil; up |-> O_ATTEN <= $past(lim); endproperty
	property p_atk_step; up |-> O_ATTEN - att_q == $past(astep) || O_ATTEN == $past(lim); endproperty
	property p_rel_step;
		dn |-> att_q - O_ATTEN == $past(rstep) || O_ATTEN == '0 || O_ATTEN == $past(lim);
	endproperty
	// Fastest rate still leaves two quiet cycles between steps
	property p_atk_space; up |=> !up [*2]; endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
	a_stat_trip: assert property (p_stat_trip) else $error("status trip bit");
	a_trip_batt: assert property (p_trip_batt) else $error("battery trip");
	a_trip_pwr: assert property (p_trip_pwr) else $error("power trip");
	a_dis: assert property (p_dis) else $error("disabled level active");
	a_ceil: assert property (p_ceil) else $error("ceiling exceeded");
	a_atk_step: assert property (p_atk_step) else $error("attack step size");
	a_rel_step: assert property (p_rel_step) else $error("release step size");
	a_atk_space: assert property (p_atk_space) else $error("attack spacing");
	c_up: cover property (up);
	c_dn: cover property (dn);
	c_trip: cover property ($rose(O_TRIP));
endmodule : bolim_props

// ---- sim/tb_bolim_top.sv ----
// Self-checking bench for the limiter configuration bank
`timescale 1ns/1ps
module tb_bolim_top;
	import bolim_pkg::*;
	logic I_CLK = 1'b0;
	logic I_RSTN = 1'b0;
	logic [7:0] I_ADDR = 8'h00;
	logic [7:0] I_WDATA = 8'h00;
	logic I_WR = 1'b0;
	logic I_RD = 1'b0;
	logic [15:0] I_BATT_MV = 16'hffff;
	logic [15:0] I_PWR_MV = 16'hffff;
	logic [7:0] O_RDATA;
	logic [18:0] O_ATTEN;
	logic O_TRIP;
	logic [7:0] rv;
	int error_cnt = 0;
	int num_checks = 0;
	int n;
	always #20 I_CLK = ~I_CLK;
	// Scaled timing: 1 cycle per us, 4 per ms
	bolim_top #(.P_CYC_PER_US(1), .P_CYC_PER_MS(4)) dut_u (.I_CLK(I_CLK), .I_RSTN(I_RSTN),
		.I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD), .I_BATT_MV(I_BATT_MV),
		.I_PWR_MV(I_PWR_MV), .O_RDATA(O_RDATA), .O_ATTEN(O_ATTEN), .O_TRIP(O_TRIP));
	task automatic chk(input string nm, input logic [18:0] seen, input logic [18:0] exp);
		num_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("unexpected %s: expected %h, seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge I_CLK);
		I_WR <= 1'b1;
		I_ADDR <= a;
		I_WDATA <= d;
		@(posedge I_CLK);
		I_WR <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a);
		@(posedge I_CLK);
		I_RD <= 1'b1;
		I_ADDR <= a;
		@(posedge I_CLK);
		I_RD <= 1'b0;
		#1 rv = O_RDATA;
	endtask : rd
	task automatic tick(input int k);
		repeat (k) @(posedge I_CLK);
		#1;
	endtask : tick
	// Bounded wait for the attenuation to move; n counts the cycles taken
	task automatic wchg(input logic [18:0] old);
		n = 0;
		while (O_ATTEN === old && n < 3000) begin
			@(posedge I_CLK);
			#1 n++;
		end
	endtask : wchg
	task automatic rail(input logic [15:0] mv);
		@(posedge I_CLK);
		I_BATT_MV <= mv;
		I_PWR_MV <= mv;
	endtask : rail
	task automatic t_regs();
		logic [7:0] ofs [5] = '{8'h26, 8'h27, 8'h28, 8'h29, 8'h2a};
		logic [7:0] rst [5] = '{8'h32, 8'h46, 8'h20, 8'h02, 8'h06};
		logic [7:0] msk [5] = '{8'hff, 8'hff, 8'hf0, 8'hfe, 8'hfe};
		for (int i = 0; i < 5; i++) begin
			rd(ofs[i]);
			chk("reset value", 19'(rv), 19'(rst[i]));
			wr(ofs[i], 8'hff);
			rd(ofs[i]);
			chk("writable bits", 19'(rv), 19'(msk[i]));
			wr(ofs[i], rst[i]);
		end
		wr(8'h10, 8'h5a);
		rd(8'h10);
		chk("unmapped", 19'(rv), 19'h0);
		rd(OFS_CTRL);
		chk("control reset", 19'(rv), 19'h0);
		wr(OFS_CTRL, 8'hff);
		rd(OFS_CTRL);
		chk("control bits", 19'(rv), 19'h05);
		wr(OFS_CTRL, 8'h00);
		wr(OFS_STATUS, 8'hff);
		rd(OFS_STATUS);
		chk("status read-only", 19'(rv), 19'h0);
		$display("test regs done");
	endtask : t_regs
	task automatic t_trip();
		logic s [7] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
		logic [7:0] c [7] = '{8'h00, 8'h00, 8'h38, 8'h39, 8'hd2, 8'hd3, 8'h00};
		logic [15:0] mv [7] = '{16'h0a8b, 16'h0a8c, 16'h157b, 16'h0000, 16'h3e7f, 16'h0000,
			16'h157c};
		logic e [7] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
		for (int i = 0; i < 7; i++) begin
			rail(mv[i]);
			wr(OFS_CTRL, {7'h0, s[i]});
			wr(OFS_L2_TRIP_THR, c[i]);
			tick(3);
			chk("trip", 19'(O_TRIP), 19'(e[i]));
			rd(OFS_STATUS);
			chk("status trip", 19'(rv[4]), 19'(e[i]));
		end
		wr(OFS_CTRL, 8'h00);
		wr(OFS_L2_TRIP_THR, 8'h00);
		rail(16'h07d0);
		tick(3);
		chk("trip enabled", 19'(O_TRIP), 19'h1);
		wr(OFS_L2_HOLD_DIS, 8'h30);
		tick(2);
		chk("trip disabled", 19'(O_TRIP), 19'h0);
		rail(16'hffff);
		wr(OFS_L2_HOLD_DIS, 8'h20);
		$display("test trip done");
	endtask : t_trip
	task automatic t_attack();
		wr(OFS_L2_REL_CEIL, 8'h3f);
		wr(OFS_L2_TRIP_THR, 8'h00);
		wr(OFS_L1_DWELL_ATK, 8'h22);
		wr(OFS_L1_RATE_REL, 8'h00);
		rail(16'd2000);
		tick(80);
		chk("dwell", O_ATTEN, 19'd0);
		wchg(19'd0);
		chk("first step", O_ATTEN, 19'd5000);
		wchg(19'd5000);
		chk("attack gap", 19'(n), 19'd3);
		wr(OFS_L2_REL_CEIL, 8'h22);
		tick(40);
		chk("ceiling", O_ATTEN, 19'd20000);
		rail(16'hffff);
		wchg(19'd20000);
		chk("hold span", 19'(n >= 41 && n <= 90), 19'd1);
		chk("release step", O_ATTEN, 19'd19375);
		wchg(19'd19375);
		chk("release gap", 19'(n), 19'd41);
		wr(OFS_L2_HOLD_DIS, 8'h30);
		tick(2);
		chk("disabled", O_ATTEN, 19'd0);
		wr(OFS_L2_HOLD_DIS, 8'h20);
		$display("test attack done");
	endtask : t_attack
	task automatic t_hold();
		wr(OFS_L2_HOLD_DIS, 8'he0);
		wr(OFS_L1_DWELL_ATK, 8'h02);
		rail(16'd2000);
		tick(30);
		rd(OFS_STATUS);
		chk("attacking", 19'(rv[3:0]), 19'(RD_ATTACK_L2));
		rail(16'hffff);
		tick(300);
		chk("endless hold", O_ATTEN, 19'd20000);
		rd(OFS_STATUS);
		chk("holding", 19'(rv[3:0]), 19'(RD_HOLD_L2));
		wr(OFS_CTRL, 8'h06);
		tick(60);
		chk("hold cleared", 19'(O_ATTEN < 19'd20000), 19'd1);
		rd(OFS_STATUS);
		chk("frozen", 19'(rv[3:0]), 19'(RD_HOLD_L2));
		wr(OFS_CTRL, 8'h00);
		rd(OFS_STATUS);
		chk("releasing", 19'(rv[3:0]), 19'(RD_RELEASE_L2));
		$display("test hold done");
	endtask : t_hold
	// Mid-run reset while releasing: everything returns to its reset value
	task automatic t_rst();
		wr(OFS_L2_REL_CEIL, 8'h05);
		wr(OFS_L1_RATE_REL, 8'he2);
		@(posedge I_CLK);
		I_RSTN <= 1'b0;
		tick(2);
		chk("reset attenuation", O_ATTEN, 19'h0);
		@(posedge I_CLK);
		I_RSTN <= 1'b1;
		rd(OFS_L2_REL_CEIL);
		chk("ceiling after reset", 19'(rv), 19'h32);
		rd(OFS_L1_RATE_REL);
		chk("release step after reset", 19'(rv), 19'h06);
		rd(OFS_STATUS);
		chk("idle after reset", 19'(rv), 19'h0);
		$display("test reset done");
	endtask : t_rst
	task automatic conclude();
		$display("checks %0d, mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : conclude
	initial begin
		repeat (10) @(posedge I_CLK);
		I_RSTN <= 1'b1;
		t_regs();
		t_trip();
		t_attack();
		t_hold();
		t_rst();
		conclude();
	end
	// Whole run needs about 860 cycles
	initial begin
		repeat (20000) @(posedge I_CLK);
		error_cnt++;
		conclude();
	end
endmodule : tb_bolim_top
bind bolim_top bolim_props #(.P_CYC_PER_US(P_CYC_PER_US), .P_CYC_PER_MS(P_CYC_PER_MS)) u_props (
	.I_CLK(I_CLK), .I_RSTN(I_RSTN), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_WR(I_WR),
	.I_RD(I_RD), .I_BATT_MV(I_BATT_MV), .I_PWR_MV(I_PWR_MV), .O_RDATA(O_RDATA),
	.O_ATTEN(O_ATTEN), .O_TRIP(O_TRIP));
